// ==== logic/ued_pkg.sv ====
package ued_pkg;
  localparam int unsigned EpSize = 8;
  localparam int unsigned NumBanks = 2;
  localparam int unsigned CntW = 4;
  localparam int unsigned FifoDepth = 4;
  localparam logic [CntW-1:0] CntReset = 4'h0;
  localparam logic [CntW-1:0] CntFull = 4'h8;

  typedef enum logic [1:0] {
    UED_CTRL,
    UED_BULK,
    UED_ISO
  } ued_type_t;

  typedef enum logic [3:0] {
    UED_TK_NONE,
    UED_TK_SETUP,
    UED_TK_OUT,
    UED_TK_IN,
    UED_TK_OUT_END,
    UED_TK_IN_DONE
  } ued_token_t;

  // link-side event from the packet engine
  typedef struct packed {
    ued_token_t kind;
    logic crcBad;
    logic [CntW:0] len;
  } ued_link_ev_t;

  // firmware control strobes
  typedef struct packed {
    logic inReadyClr;
    logic outRecvClr;
    logic setupRecvClr;
    logic bankCtrlClr;
    logic killBank;
    logic underflowClr;
    logic overflowClr;
    logic crcErrClr;
    logic nakedInClr;
  } ued_fw_cmd_t;

  typedef struct packed {
    logic inReady;
    logic outRecv;
    logic setupRecv;
    logic nakedIn;
    logic underflow;
    logic overflow;
    logic crcErr;
  } ued_flags_t;

  typedef struct packed {
    logic inReady;
    logic outRecv;
    logic underflow;
    logic overflow;
    logic crcErr;
    logic nakedIn;
  } ued_irq_en_t;

  localparam ued_flags_t FlagsReset = '0;
endpackage

// ==== logic/ued_fifo.sv ====
`timescale 1ns/10ps
module ued_fifo #(
  parameter int unsigned Width = 8,
  parameter int unsigned Depth = 4
) (
  input wire logic clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic flush, // drop contents
  input wire logic inValid, // write valid
  output logic inReady, // space free
  input wire logic [Width-1:0] inData, // write data
  output logic outValid, // data held
  input wire logic outReady, // reader takes
  output logic [Width-1:0] outData // read data
);
  localparam int unsigned Aw = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [Aw-1:0] wrPtr_q;
  logic [Aw-1:0] rdPtr_q;
  logic [Aw:0] count_q;
  logic doWr;
  logic doRd;

  assign inReady = (count_q != (Aw+1)'(Depth));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == Aw'(Depth - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= (rdPtr_q == Aw'(Depth - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (Aw+1)'(doWr) - (Aw+1)'(doRd);
    end
  end
endmodule // ued_fifo

// ==== logic/ued_endpoint.sv ====
`timescale 1ns/10ps
// Behaviour
// - setup always acked, sets setup flag only
// - control endpoints read bank/rw bits zero
// - setup flag clear frees setup bank
// - control in-ready; clearing sends loaded packet (here clearing only drops the flag)
// - naked-in flag set on naked IN
// - first control-read status token NAKed
// - status stage discards data, ignores clear
// - out retry acked, sets out and in-ready
// - setup wins, clears flags, resets fifo
// - zero-length control out zeroes byte count
// - in-ready with bank bit when bank free
// - bank clear releases bank, switches next
// - in rw-allowed while bank not full
// - next bank ready re-sets flag at once
// - zero-length out aborts; kill drops bank
// - out-received with bank bit when full
// - out rw-allowed while unread data left
// - iso underflow: empty in, full out drop
// - oversize out acked, truncated, overflow flag
// - iso out crc error stored, flagged
module ued_endpoint (
  input wire logic clk, // 100 MHz clock
  input wire logic sys_rst, // sync reset, high
  input wire ued_pkg::ued_type_t epType, // endpoint type
  input wire logic epDirIn, // 1 = IN endpoint
  input wire logic ctrlReadXfer, // control read in progress
  input wire ued_pkg::ued_irq_en_t irqEn, // interrupt enables
  input wire ued_pkg::ued_link_ev_t linkEv, // link event pulse
  output logic linkAck, // answer ACK
  output logic linkNak, // answer NAK
  output logic linkZlp, // send zero-length packet
  input wire ued_pkg::ued_fw_cmd_t fwCmd, // firmware strobes
  input wire logic wrValid, // firmware write byte
  output logic wrReady, // write accepted
  input wire logic [7:0] wrData, // write byte
  output logic rdValid, // read byte available
  input wire logic rdReady, // firmware takes byte
  output logic [7:0] rdData, // read byte
  input wire logic rxValid, // link receive byte
  input wire logic [7:0] rxData, // link receive data
  output ued_pkg::ued_flags_t flags, // status flags
  output logic bankCtrl, // bank control bit
  output logic rwAllowed, // read/write allowed
  output logic [ued_pkg::CntW-1:0] byteCount, // byte count
  output logic [ued_pkg::CntW-1:0] txLen, // length of sent bank
  output logic endpointIrq // endpoint interrupt
);
  import ued_pkg::*;

  typedef enum logic [1:0] {
    UED_CS_IDLE,
    UED_CS_DATA,
    UED_CS_STATUS_WAIT,
    UED_CS_STATUS
  } ued_ctl_state_t;

  ued_ctl_state_t ctlState_q;
  ued_flags_t flags_q;
  logic [NumBanks-1:0] bankBusy_q;
  logic [CntW-1:0] bankLen_q [NumBanks];
  logic curBank_q;
  logic hostBank_q;
  logic bankCtrl_q;
  logic [CntW-1:0] count_q;
  logic [CntW-1:0] txLen_q;
  logic isCtrl;
  logic isIso;
  logic fifoFlush;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutReady;
  logic rxFits;
  logic evSetup;
  logic evOut;
  logic evIn;
  logic outBankFull;
  logic [7:0] store_q [EpSize];
  logic [CntW-1:0] storeWr_q;
  logic [CntW-1:0] storePump_q;
  logic storeFull;
  logic storeIn;
  logic [7:0] storeInData;
  logic storePump;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic [7:0] fifoInData;
  logic bankRestart;

  assign isCtrl = (epType == UED_CTRL);
  assign isIso = (epType == UED_ISO);
  assign evSetup = isCtrl && (linkEv.kind == UED_TK_SETUP);
  assign evOut = (linkEv.kind == UED_TK_OUT_END);
  assign evIn = (linkEv.kind == UED_TK_IN);
  assign outBankFull = bankBusy_q[hostBank_q];

  ////////////////////////////////////////////////////////////////////////
  // data path: bank store plus a 4-word fifo on the firmware side
  // out: link -> store -> fifo -> firmware
  // in: firmware -> fifo -> store
  // keep only the bytes that fit
  assign storeFull = (storeWr_q == CntFull);
  assign rxFits = !storeFull;
  assign fifoFlush = evSetup || fwCmd.killBank ||
    (ctlState_q == UED_CS_STATUS && isCtrl);
  // control flag clear frees the bank
  assign bankRestart = fifoFlush || (fwCmd.bankCtrlClr && bankCtrl_q) ||
    (isCtrl && (fwCmd.setupRecvClr || fwCmd.outRecvClr));
  assign storeIn = epDirIn ? (fifoOutValid && !storeFull) :
    (rxValid && rxFits);
  assign storeInData = epDirIn ? fifoOutData : rxData;
  assign storePump = !epDirIn && (storePump_q != storeWr_q) && fifoInReady;
  assign fifoInValid = epDirIn ? wrValid : (storePump_q != storeWr_q);
  assign fifoInData = epDirIn ? wrData : store_q[storePump_q[CntW-2:0]];
  assign fifoOutReady = epDirIn ? !storeFull : rdReady;
  assign rdValid = !epDirIn && fifoOutValid;
  assign rdData = fifoOutData;
  // in writes accepted only while bank not full
  assign wrReady = epDirIn && fifoInReady && (count_q != CntFull);

  ued_fifo #(
    .Width(8),
    .Depth(FifoDepth)
  ) uFifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(fifoFlush),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  ////////////////////////////////////////////////////////////////////////
  // bank store: bytes of the current bank, indexed from its start
  always_ff @(posedge clk) begin
    if (storeIn) begin
      store_q[storeWr_q[CntW-2:0]] <= storeInData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || bankRestart) begin
      storeWr_q <= CntReset;
      storePump_q <= CntReset;
    end else begin
      if (storeIn) begin
        storeWr_q <= storeWr_q + 1'b1;
      end
      if (storePump) begin
        storePump_q <= storePump_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte count of the firmware-side bank
  always_ff @(posedge clk) begin
    if (sys_rst || bankRestart) begin
      count_q <= CntReset;
    end else if (isCtrl && evOut && linkEv.len == '0) begin
      count_q <= CntReset;
    end else if (epDirIn) begin
      if (wrValid && wrReady) begin
        count_q <= count_q + 1'b1;
      end
    end else begin
      // count falls to zero as bank drains
      count_q <= count_q + CntW'(storeIn) - CntW'(rdValid && rdReady);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank ownership and switching
  always_ff @(posedge clk) begin
    if (sys_rst || evSetup) begin
      bankBusy_q <= '0;
      curBank_q <= 1'b0;
      hostBank_q <= 1'b0;
      txLen_q <= CntReset;
      for (int i = 0; i < NumBanks; i++) begin
        bankLen_q[i] <= CntReset;
      end
    end else begin
      // release bank and move to next
      if (fwCmd.bankCtrlClr && bankCtrl_q && !isCtrl) begin
        curBank_q <= ~curBank_q;
        if (epDirIn) begin
          bankBusy_q[curBank_q] <= 1'b1;
          bankLen_q[curBank_q] <= count_q;
        end else begin
          bankBusy_q[curBank_q] <= 1'b0;
        end
      end else if (fwCmd.killBank && epDirIn) begin
        bankBusy_q[~curBank_q] <= 1'b0;
      end
      if (epDirIn && linkEv.kind == UED_TK_IN_DONE) begin
        bankBusy_q[hostBank_q] <= 1'b0;
        hostBank_q <= ~hostBank_q;
      end else if (epDirIn && evIn) begin
        txLen_q <= bankLen_q[hostBank_q];
      end
      // out into full iso bank is dropped
      if (!epDirIn && evOut && !outBankFull) begin
        bankBusy_q[hostBank_q] <= 1'b1;
        hostBank_q <= ~hostBank_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control transfer stage tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctlState_q <= UED_CS_IDLE;
    end else if (evSetup) begin
      ctlState_q <= UED_CS_DATA;
    end else if (isCtrl) begin
      unique case (ctlState_q)
        UED_CS_IDLE: ctlState_q <= UED_CS_IDLE;
        UED_CS_DATA: begin
          if (ctrlReadXfer && evOut) begin
            ctlState_q <= UED_CS_STATUS_WAIT;
          end else if (!ctrlReadXfer && evIn) begin
            ctlState_q <= UED_CS_STATUS;
          end
        end
        UED_CS_STATUS_WAIT: begin
          // hold until the first status token
          if (evIn) begin
            ctlState_q <= UED_CS_STATUS;
          end
        end
        // wait for next setup after status
        UED_CS_STATUS: ctlState_q <= UED_CS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link answers
  always_comb begin
    linkAck = 1'b0;
    linkNak = 1'b0;
    linkZlp = 1'b0;
    if (evSetup) begin
      linkAck = 1'b1;
    end else if (evOut) begin
      linkAck = isCtrl || !outBankFull;
      linkNak = !isCtrl && !isIso && outBankFull;
    end else if (evIn) begin
      if (isCtrl && ctlState_q == UED_CS_STATUS_WAIT) begin
        linkNak = 1'b1;
      end else if (!bankBusy_q[hostBank_q]) begin
        // empty iso in sends zero-length packet
        linkZlp = isIso;
        linkNak = !isIso;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over firmware clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= FlagsReset;
    end else if (evSetup) begin
      // setup flag only, no out flag
      flags_q <= FlagsReset;
      flags_q.setupRecv <= 1'b1;
    end else begin
      if (fwCmd.setupRecvClr) begin
        flags_q.setupRecv <= 1'b0;
      end
      if (fwCmd.inReadyClr && !(isCtrl && ctlState_q == UED_CS_STATUS)) begin
        flags_q.inReady <= 1'b0;
      end
      // in-ready set when current bank free
      // next bank free sets it at once
      if (epDirIn && !isCtrl && !bankBusy_q[curBank_q] &&
          !bankCtrl_q && !fwCmd.bankCtrlClr) begin
        flags_q.inReady <= 1'b1;
      end
      if (isCtrl && linkEv.kind == UED_TK_IN_DONE) begin
        flags_q.inReady <= 1'b1;
      end
      if (fwCmd.outRecvClr) begin
        flags_q.outRecv <= 1'b0;
      end
      // out-received with bank bit when full
      // next full bank re-flags at once
      if (!epDirIn && !isCtrl && bankBusy_q[curBank_q] &&
          !(fwCmd.bankCtrlClr && bankCtrl_q) && !bankCtrl_q) begin
        flags_q.outRecv <= 1'b1;
      end
      if (isCtrl && evOut) begin
        flags_q.outRecv <= 1'b1;
        if (ctrlReadXfer) begin
          flags_q.inReady <= 1'b1;
        end
      end
      if (fwCmd.nakedInClr) begin
        flags_q.nakedIn <= 1'b0;
      end
      if (linkNak && evIn) begin
        flags_q.nakedIn <= 1'b1;
      end
      if (fwCmd.underflowClr) begin
        flags_q.underflow <= 1'b0;
      end
      if (isIso && ((evIn && linkZlp) || (evOut && outBankFull))) begin
        flags_q.underflow <= 1'b1;
      end
      if (fwCmd.overflowClr) begin
        flags_q.overflow <= 1'b0;
      end
      if (evOut && linkEv.len > (CntW+1)'(EpSize)) begin
        flags_q.overflow <= 1'b1;
      end
      if (fwCmd.crcErrClr) begin
        flags_q.crcErr <= 1'b0;
      end
      // iso out crc error still stored
      if (isIso && !epDirIn && evOut && linkEv.crcBad) begin
        flags_q.crcErr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bank control bit
  always_ff @(posedge clk) begin
    if (sys_rst || evSetup) begin
      bankCtrl_q <= 1'b0;
    end else if (fwCmd.bankCtrlClr) begin
      bankCtrl_q <= 1'b0;
    end else if (!isCtrl) begin
      bankCtrl_q <= epDirIn ? !bankBusy_q[curBank_q] : bankBusy_q[curBank_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign flags = flags_q;
  // bank and rw bits read zero on control
  assign bankCtrl = isCtrl ? 1'b0 : bankCtrl_q;
  assign rwAllowed = isCtrl ? 1'b0 :
    (epDirIn ? (bankCtrl_q && count_q != CntFull)
             : (bankCtrl_q && count_q != '0));
  assign byteCount = count_q;
  assign txLen = txLen_q;
  assign endpointIrq = (flags_q.inReady && irqEn.inReady) ||
    (flags_q.outRecv && irqEn.outRecv) ||
    (flags_q.underflow && irqEn.underflow) ||
    (flags_q.overflow && irqEn.overflow) ||
    (flags_q.crcErr && irqEn.crcErr) ||
    (flags_q.nakedIn && irqEn.nakedIn) ||
    flags_q.setupRecv;
endmodule // ued_endpoint

// ==== tb/ued_endpoint_props.sv ====
`timescale 1ns/10ps
module ued_endpoint_props (
  input wire logic clk, // clock
  input wire logic sys_rst, // sync reset
  input wire ued_pkg::ued_type_t epType, // type
  input wire logic epDirIn, // direction
  input wire ued_pkg::ued_irq_en_t irqEn, // enables
  input wire ued_pkg::ued_link_ev_t linkEv, // link event
  input wire logic linkAck, // ack
  input wire logic linkZlp, // zero-length
  input wire ued_pkg::ued_flags_t flags, // flags
  input wire logic bankCtrl, // bank bit
  input wire logic rwAllowed, // rw allowed
  input wire logic [ued_pkg::CntW-1:0] byteCount, // count
  input wire logic endpointIrq // interrupt
);
  import ued_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic isOutEnd;
  assign isOutEnd = linkEv.kind == UED_TK_OUT_END;
  ////////////////////////////////////////////////////////////////////
  setup_ack_a: assert property (
    epType == UED_CTRL && linkEv.kind == UED_TK_SETUP |-> linkAck)
    else $error("setup not acked");
  setup_flag_a: assert property (
    epType == UED_CTRL && linkEv.kind == UED_TK_SETUP
    |=> flags.setupRecv && !flags.outRecv)
    else $error("setup flags wrong");
  ctrl_bits_zero_a: assert property (
    epType == UED_CTRL |-> !bankCtrl && !rwAllowed)
    else $error("control bank bits not zero");
  zlp_count_a: assert property (
    epType == UED_CTRL && isOutEnd && linkEv.len == 0 |=> byteCount == 0)
    else $error("zero-length out kept count");
  in_full_a: assert property (
    epType != UED_CTRL && epDirIn && byteCount == CntFull |-> !rwAllowed)
    else $error("rw allowed on full bank");
  out_empty_a: assert property (
    epType != UED_CTRL && !epDirIn && byteCount == 0 |-> !rwAllowed)
    else $error("rw allowed on empty bank");
  overflow_flag_a: assert property (
    isOutEnd && linkAck && linkEv.len > EpSize
    |=> flags.overflow && byteCount == CntFull ##1 flags.outRecv)
    else $error("overflow not flagged");
  crc_flag_a: assert property (
    epType == UED_ISO && !epDirIn && isOutEnd && linkEv.crcBad
    |=> flags.crcErr || flags.underflow) else $error("crc not flagged");
  iso_under_a: assert property (
    epType == UED_ISO && linkEv.kind == UED_TK_IN && linkZlp
    |=> flags.underflow) else $error("underflow not flagged");
  irq_out_a: assert property (
    (flags.outRecv && irqEn.outRecv) || (flags.inReady && irqEn.inReady)
    |-> endpointIrq) else $error("irq missing");
  setup_cov: cover property (linkEv.kind == UED_TK_SETUP);
  over_cov: cover property ($rose(flags.overflow));
  zlp_cov: cover property (linkZlp);
endmodule // ued_endpoint_props
bind ued_endpoint ued_endpoint_props u_props (.clk(clk), .sys_rst(sys_rst),
  .epType(epType), .epDirIn(epDirIn), .irqEn(irqEn), .linkEv(linkEv),
  .linkAck(linkAck), .linkZlp(linkZlp), .flags(flags),
  .bankCtrl(bankCtrl), .rwAllowed(rwAllowed), .byteCount(byteCount),
  .endpointIrq(endpointIrq));

// ==== tb/ued_host_model.sv ====
`timescale 1ns/10ps
module ued_host_model (
  input wire logic clk, // clock
  output ued_pkg::ued_link_ev_t linkEv, // token events
  output logic rxValid, // byte strobe
  output logic [7:0] rxData, // byte
  input wire logic linkAck, // ack answer
  input wire logic linkNak, // nak answer
  input wire logic linkZlp // zero-length answer
);
  import ued_pkg::*;
  logic [7:0] sent[$];
  logic ack, nak, zlp;
  initial begin
    linkEv = '0;
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  // payload bytes first, then one event; answer taken just before its edge
  task automatic tok(input ued_token_t k, input int n, input logic bad);
    if (n > 0) sent.delete();
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rxValid = 1'b1;
      rxData = 8'($urandom);
      sent.push_back(rxData);
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxData = ~rxData;
    linkEv = '{kind: k, crcBad: bad, len: 5'(n)};
    // answer is combinational; take it settled, just before the edge
    #4;
    ack = linkAck;
    nak = linkNak;
    zlp = linkZlp;
    @(negedge clk);
    linkEv = '0;
  endtask
endmodule // ued_host_model

// ==== tb/usb_device_endpoint_bank_flow_test.sv ====
`timescale 1ns/10ps
module usb_device_endpoint_bank_flow_test;
  import ued_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, epDirIn = 1'b0, ctrlReadXfer = 1'b0;
  ued_type_t epType = UED_CTRL;
  ued_irq_en_t irqEn = '1;
  ued_fw_cmd_t fwCmd = '0;
  ued_link_ev_t linkEv;
  ued_flags_t flags;
  logic wrValid = 1'b0, rdReady = 1'b0, wrReady, rdValid, rxValid;
  logic linkAck, linkNak, linkZlp, bankCtrl, rwAllowed, endpointIrq;
  logic [7:0] wrData = 8'h00, rdData, rxData;
  logic [CntW-1:0] byteCount, txLen;
  int n_errors = 0, cmp_count = 0, cyc = 0, n;
  initial forever #5 clk = ~clk;
  ued_endpoint dut_u (.clk(clk), .sys_rst(sys_rst), .epType(epType),
    .epDirIn(epDirIn), .ctrlReadXfer(ctrlReadXfer), .irqEn(irqEn),
    .linkEv(linkEv), .linkAck(linkAck), .linkNak(linkNak),
    .linkZlp(linkZlp), .fwCmd(fwCmd), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
    .rxValid(rxValid), .rxData(rxData), .flags(flags), .bankCtrl(bankCtrl),
    .rwAllowed(rwAllowed), .byteCount(byteCount), .txLen(txLen),
    .endpointIrq(endpointIrq));
  ued_host_model hostU (.clk(clk), .linkEv(linkEv), .rxValid(rxValid),
    .rxData(rxData), .linkAck(linkAck), .linkNak(linkNak),
    .linkZlp(linkZlp));
  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rst(input ued_type_t t, input logic d);
    @(negedge clk);
    sys_rst = 1'b1;
    epType = t;
    epDirIn = d;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // one-cycle firmware strobe, bit order as the struct declares it
  task automatic fw(input logic [8:0] m);
    @(negedge clk);
    fwCmd = ued_fw_cmd_t'(m);
    @(negedge clk);
    fwCmd = '0;
  endtask
  task automatic rd(input int cnt);
    int k = 0;
    @(negedge clk);
    rdReady = 1'b1;
    while (k < cnt) begin
      if (rdValid === 1'b1) begin
        chk(rdData, hostU.sent[k]);
        k++;
      end
      @(negedge clk);
    end
    rdReady = 1'b0;
  endtask
  task automatic wr(input int cnt);
    int k = 0;
    @(negedge clk);
    wrValid = 1'b1;
    wrData = 8'($urandom);
    while (k < cnt) begin
      if (wrReady === 1'b1) begin
        k++;
        @(negedge clk);
        wrData = 8'($urandom);
      end else begin
        @(negedge clk);
      end
    end
    wrValid = 1'b0;
  endtask
  task automatic outPkt(input int cnt, input logic bad);
    hostU.tok(UED_TK_OUT, 0, 1'b0);
    hostU.tok(UED_TK_OUT_END, cnt, bad);
    // bank flags follow the bank state one edge later
    @(negedge clk);
  endtask
  initial begin
    void'($urandom(37179));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({flags, bankCtrl, byteCount}, 0);
    // control endpoint: setup, zero-length out, setup priority
    hostU.tok(UED_TK_SETUP, 8, 1'b0);
    chk(hostU.ack, 1);
    chk({flags.setupRecv, flags.outRecv}, 2'b10);
    chk({bankCtrl, rwAllowed, endpointIrq}, 3'b001);
    fw(9'h040);
    chk(flags.setupRecv, 0);
    outPkt(0, 1'b0);
    chk(byteCount, CntReset);
    fw(9'h080);
    outPkt(3, 1'b0);
    chk({flags.outRecv, byteCount}, {1'b1, 4'h3});
    hostU.tok(UED_TK_SETUP, 8, 1'b0);
    chk({flags.setupRecv, flags.outRecv}, 2'b10);
    // control read: out retry, then first status token
    ctrlReadXfer = 1'b1;
    outPkt(0, 1'b0);
    chk({hostU.ack, flags.outRecv, flags.inReady}, 3'b111);
    hostU.tok(UED_TK_IN, 0, 1'b0);
    chk({hostU.nak, flags.nakedIn}, 2'b11);
    ctrlReadXfer = 1'b0;
    $display("control test done");
    // bulk out: masked then enabled irq, read back, overflow
    rst(UED_BULK, 1'b0);
    irqEn = '0;
    n = 1 + ($urandom % EpSize);
    outPkt(n, 1'b0);
    chk({hostU.ack, flags.outRecv, bankCtrl}, 3'b111);
    chk(byteCount, n);
    chk(endpointIrq, 0);
    irqEn = '1;
    @(negedge clk);
    chk(endpointIrq, 1);
    fw(9'h080);
    chk({flags.outRecv, bankCtrl}, 2'b01);
    rd(n);
    chk({byteCount, rwAllowed}, 0);
    fw(9'h020);
    outPkt(10, 1'b0);
    chk({hostU.ack, flags.overflow, flags.outRecv}, 3'b111);
    chk(byteCount, CntFull);
    rd(EpSize);
    $display("bulk out test done");
    // bulk in: fill bank, release, switch, send
    rst(UED_BULK, 1'b1);
    chk({flags.inReady, bankCtrl, endpointIrq}, 3'b111);
    fw(9'h100);
    chk({flags.inReady, bankCtrl}, 2'b01);
    wr(EpSize);
    @(negedge clk);
    chk({byteCount, rwAllowed}, {CntFull, 1'b0});
    fw(9'h020);
    @(negedge clk);
    chk({flags.inReady, bankCtrl}, 2'b11);
    hostU.tok(UED_TK_IN, 0, 1'b0);
    chk(txLen, CntFull);
    hostU.tok(UED_TK_IN_DONE, 0, 1'b0);
    hostU.tok(UED_TK_IN, 0, 1'b0);
    chk({hostU.nak, flags.nakedIn}, 2'b11);
    $display("bulk in test done");
    // isochronous: empty in bank, crc-damaged out
    rst(UED_ISO, 1'b1);
    hostU.tok(UED_TK_IN, 0, 1'b0);
    chk({hostU.zlp, flags.underflow}, 2'b11);
    rst(UED_ISO, 1'b0);
    outPkt(4, 1'b1);
    chk({flags.crcErr, flags.outRecv, byteCount}, {2'b11, 4'h4});
    rd(4);
    $display("iso test done");
    summarize();
  end
endmodule // usb_device_endpoint_bank_flow_test
